//--- madc_ctrl.sv
// Control and serial port of an eight-input multiplexed converter.
// Assumes the host drives frame, shift clock and serial input asynchronously;
// the shift clock is sampled, never used as a clock.
// Summary of operation
// (RL1) Frame rising edge starts a conversion
// (RL2) Started conversion runs to end unchanged
// (RL3) Between conversions take config, shift result
// (RL4) Host allows 1.5 us acquisition
// (RL5) Bits resolved MSB first, latched at once
// (RL6) Config word is seven bits, fixed order
// (RL7) Unipolar straight binary, bipolar twos complement
// (RL8) Last config bit requests sleep
// (RL9) Differential pairs chosen by address, odd flips
// (RL10) Single-ended channel is twice address plus odd
// (RL11) Shared bit makes input seven common negative
// (RL12) Frame pin starts and delimits transfers
// (RL13) Serial bits follow the host shift clock
// (RL14) Config captured bit by bit from input
// (RL15) Result shifted out bit by bit
// (RL16) Host captures falling edge for fast clocks
// (RL17) Result width sixteen or twelve bits
// (RL18) Shared negative uses input seven as minus
// (RL19) Frame low after conversion enables output
// (RL20) Sample input on rise, update output on fall
// (RL21) Config MSB first, applied to next acquisition
// (RL22) Output released while frame high or converting
`timescale 1ns/100ps
module madc_ctrl import madc_pkg::*; #(
  parameter int unsigned RES_BITS = 16, // 16 or 12 bit variant
  parameter int unsigned CONV_CYC = MADC_CONV_CYC // Conversion length in cycles
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_frame_and_start_pin, // Frame / convert pin
  input wire logic i_shift_clk, // Host shift clock pin
  input wire logic i_serial_config_in, // Serial configuration input
  input wire logic i_cmp_high, // Comparator decision, core clock domain
  output logic o_serial_result_out, // Serial result data
  output logic o_serial_result_oe, // High while driving the result pin
  output logic [3:0] o_pos_select, // Positive input, 0..7 or none
  output logic [3:0] o_neg_select, // Negative input, 0..7, ground or none
  output logic o_unipolar, // Polarity mode in force
  output logic o_sleeping, // Power-down state
  output logic o_converting // Conversion in progress
);
  localparam int unsigned STEP_CYC = CONV_CYC / RES_BITS; // Cycles per bit decision
  logic [2:0] frame_sync_reg; // Frame pin: two sync stages plus edge history
  logic [2:0] sck_sync_reg; // Shift clock pin: two sync stages plus edge history
  logic [2:0] sdi_sync_reg; // Serial input pin: two sync stages plus one delay
  logic frame_rise; // Frame pin went high
  logic frame_low; // Frame pin is low, port may open
  logic sck_rise; // Shift clock went high, take an input bit
  logic sck_fall; // Shift clock went low, present the next output bit
  logic sdi_bit; // Input bit lined up with the shift clock edge detector
  madc_state_t state_reg;
  logic [15:0] cnt_reg; // Step timer
  logic step_pulse;
  logic [RES_BITS-1:0] sar_word; // SAR contents
  logic sar_done;
  logic [RES_BITS-1:0] latch_reg; // Output latches
  logic [RES_BITS-1:0] shout_reg; // Result shifter
  logic [6:0] shin_reg; // Config shifter
  logic [2:0] bitcnt_reg; // Config bits received
  logic [6:0] cfg_reg; // Word applied to next acquisition
  logic shift_enable; // Serial port open
  // Refuse variants the step timer and the shifters cannot serve
  if (RES_BITS != 16 && RES_BITS != 12) begin : g_bad_res
    $error("madc_ctrl: RES_BITS must be 12 or 16"); // see (RL17)
  end
  if (CONV_CYC < RES_BITS || CONV_CYC > 65535) begin : g_bad_conv
    $error("madc_ctrl: CONV_CYC out of range");
  end
  // Synchronise the host pins; stage 0 is read only by stage 1
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      frame_sync_reg <= 3'h7; // Idle high, so no false start follows reset
      sck_sync_reg <= 3'h0;
      sdi_sync_reg <= 3'h0;
    end else begin
      frame_sync_reg <= {frame_sync_reg[1:0], i_frame_and_start_pin};
      sck_sync_reg <= {sck_sync_reg[1:0], i_shift_clk};
      sdi_sync_reg <= {sdi_sync_reg[1:0], i_serial_config_in};
    end
  end
  // Edges are found between the second and third stage
  assign frame_rise = frame_sync_reg[1] & ~frame_sync_reg[2];
  assign frame_low = ~frame_sync_reg[1];
  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2]; // see (RL13)
  assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  assign sdi_bit = sdi_sync_reg[2];
  // One bit decision every STEP_CYC cycles of a conversion
  assign step_pulse = (state_reg == MADC_CONVERT) && (cnt_reg == 16'(STEP_CYC - 1));
  // Phase machine: frame rise starts, conversion ignores the pin until done
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= MADC_ACQUIRE;
    end else begin
      case (state_reg)
        MADC_ACQUIRE, MADC_SLEEP: begin
          if (frame_rise) state_reg <= MADC_CONVERT; // see (RL1) (RL12)
        end
        MADC_CONVERT: begin
          if (sar_done) state_reg <= cfg_reg[MADC_F_SLEEP] ? MADC_SLEEP : MADC_ACQUIRE; // see (RL2) (RL8)
        end
        default: state_reg <= MADC_ACQUIRE;
      endcase
    end
  end
  // Bit-decision timer, cleared outside conversions and after every step
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_reg != MADC_CONVERT || step_pulse) cnt_reg <= 16'h0;
    else cnt_reg <= cnt_reg + 16'h1;
  end
  // Bit decisions restart with every accepted frame rise
  madc_sar_step #(.WIDTH(RES_BITS)) u_sar (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_start(frame_rise && state_reg != MADC_CONVERT),
    .i_step(step_pulse),
    .i_cmp_high(i_cmp_high),
    .o_word(sar_word),
    .o_done(sar_done)
  );
  // Whole word into the output latches in one step at the end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) latch_reg <= '0;
    else if (sar_done) latch_reg <= sar_word ^ {~cfg_reg[MADC_F_UNIPOLAR], {(RES_BITS-1){1'b0}}}; // see (RL5) (RL7)
  end
  // Port opens only with the frame low and no conversion running
  assign shift_enable = frame_low && state_reg != MADC_CONVERT; // see (RL19) (RL22)
  // Result shifter: load on frame fall, MSB after falling shift clock edges
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      shout_reg <= '0;
    end else if (!shift_enable) begin
      shout_reg <= latch_reg; // see (RL3)
    end else if (sck_fall) begin
      shout_reg <= {shout_reg[RES_BITS-2:0], 1'b0}; // see (RL15) (RL20)
    end
  end
  // Config shifter: samples on rising shift clock edges, MSB first
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      shin_reg <= MADC_CFG_RESET;
      bitcnt_reg <= 3'h0;
    end else if (!shift_enable) begin
      bitcnt_reg <= 3'h0;
    end else if (sck_rise && bitcnt_reg != 3'(MADC_CFG_BITS)) begin
      shin_reg <= {shin_reg[5:0], sdi_bit}; // see (RL14) (RL20) (RL21) (RL6)
      bitcnt_reg <= bitcnt_reg + 3'h1;
    end
  end
  // A complete word takes effect when the frame closes; partial words are dropped
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) cfg_reg <= MADC_CFG_RESET;
    else if (frame_rise && bitcnt_reg == 3'(MADC_CFG_BITS) && state_reg != MADC_CONVERT) cfg_reg <= shin_reg; // see (RL21)
  end
  // Registered outputs: serial pin, enable, mux selection and status
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_serial_result_out <= 1'b0;
      o_serial_result_oe <= 1'b0;
      o_pos_select <= MADC_SEL_NONE;
      o_neg_select <= MADC_SEL_NONE;
      o_unipolar <= 1'b0;
      o_sleeping <= 1'b0;
      o_converting <= 1'b0;
    end else begin
      o_serial_result_out <= shift_enable & shout_reg[RES_BITS-1]; // see (RL7)
      o_serial_result_oe <= shift_enable; // see (RL22)
      o_unipolar <= cfg_reg[MADC_F_UNIPOLAR]; // see (RL7)
      o_sleeping <= state_reg == MADC_SLEEP;
      o_converting <= state_reg == MADC_CONVERT;
      // Selection follows the config only outside conversions
      if (state_reg != MADC_CONVERT) begin
        o_pos_select <= {1'b0, cfg_reg[MADC_F_ADDR_HI], cfg_reg[MADC_F_ADDR_LO], cfg_reg[MADC_F_ODD]}; // see (RL9) (RL10)
        if (cfg_reg[MADC_F_SHARED]) o_neg_select <= 4'h7; // see (RL11) (RL18)
        else if (cfg_reg[MADC_F_SINGLE]) o_neg_select <= MADC_SEL_GND; // see (RL10)
        else o_neg_select <= {1'b0, cfg_reg[MADC_F_ADDR_HI], cfg_reg[MADC_F_ADDR_LO], ~cfg_reg[MADC_F_ODD]}; // see (RL9)
      end
    end
  end
  // Assertions
  sequence s_start;
    frame_rise && state_reg != MADC_CONVERT;
  endsequence
  a_start_converts: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL1)
    s_start |=> state_reg == MADC_CONVERT) else $error("conversion did not start");
  a_conv_unbroken: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL2)
    state_reg == MADC_CONVERT && !sar_done |=> state_reg == MADC_CONVERT) else $error("conversion aborted");
  a_latch_at_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL5)
    sar_done |=> latch_reg == ($past(sar_word) ^ {~$past(cfg_reg[MADC_F_UNIPOLAR]), {(RES_BITS-1){1'b0}}}))
    else $error("result not latched");
  // Bipolar results carry the sign in two's complement form
  a_sign_format: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL7)
    sar_done && !cfg_reg[MADC_F_UNIPOLAR] |=> latch_reg[RES_BITS-1] != $past(sar_word[RES_BITS-1]))
    else $error("sign not formed");
  a_out_released: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL22)
    (frame_sync_reg[1] || state_reg == MADC_CONVERT) |=> !o_serial_result_oe) else $error("output driven");
  a_sleep_entry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL8)
    sar_done && cfg_reg[MADC_F_SLEEP] |=> state_reg == MADC_SLEEP) else $error("sleep not entered");
  a_shared_neg: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL11)
    state_reg != MADC_CONVERT && cfg_reg[MADC_F_SHARED] |=> o_neg_select == 4'h7) else $error("bad negative");
  a_single_gnd: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL10)
    state_reg != MADC_CONVERT && cfg_reg[MADC_F_SINGLE] && !cfg_reg[MADC_F_SHARED] |=> o_neg_select == MADC_SEL_GND)
    else $error("bad ground select");
  a_diff_pair: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL9)
    state_reg != MADC_CONVERT && !cfg_reg[MADC_F_SINGLE] && !cfg_reg[MADC_F_SHARED]
    |=> (o_pos_select ^ o_neg_select) == 4'h1) else $error("bad pair");
  a_cfg_shift: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL14)
    shift_enable && sck_rise && bitcnt_reg == 3'h0 |=> shin_reg[0] == $past(sdi_bit) && bitcnt_reg == 3'h1)
    else $error("config bit lost");
  a_out_shift: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL15)
    shift_enable && sck_fall |=> shout_reg[RES_BITS-1] == $past(shout_reg[RES_BITS-2])) else $error("shift wrong");
  // Port opens once the frame is low after a conversion
  a_oe_in_frame: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL19)
    frame_low && state_reg != MADC_CONVERT |=> o_serial_result_oe) else $error("port not opened");
  // A full word seen at the closing rise becomes the config in force
  sequence s_word_ready;
    frame_rise && bitcnt_reg == 3'(MADC_CFG_BITS) && state_reg != MADC_CONVERT;
  endsequence
  a_cfg_applied: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL21)
    s_word_ready |=> cfg_reg == $past(shin_reg)) else $error("config word not applied");
  // Unipolar mode in force is shown on its output
  a_unipolar_out: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL7)
    cfg_reg[MADC_F_UNIPOLAR] |=> o_unipolar) else $error("polarity mode not shown");
  // Mux selection stays put while a conversion runs
  a_select_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see (RL2)
    state_reg == MADC_CONVERT |=> $stable(o_pos_select) && $stable(o_neg_select))
    else $error("selection moved during conversion");
endmodule // madc_ctrl

//--- madc_host_model.sv
// Host controller model: frames transfers, shifts config in and result out.
// Assumes one core clock paces every pin change; shift clock period is 8 cycles.
`timescale 1ns/100ps
module madc_host_model (
  input wire logic i_core_clk,
  input wire logic i_serial_result_out, // Result pin from the device
  input wire logic i_serial_result_oe, // High while the device drives the result pin
  input wire logic i_converting, // Conversion in progress
  output logic o_frame, // Frame / start pin, idle high
  output logic o_shift_clk, // Shift clock, still and low outside frames
  output logic o_sdi // Serial configuration data
);
  // Pins idle: frame high, clock low
  initial begin
    o_frame = 1'b1;
    o_shift_clk = 1'b0;
    o_sdi = 1'b0;
  end
  // Wait a number of core cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // One frame, then the rise that starts the next conversion; glitch toggles frame mid-conversion
  task automatic xfer(input logic [6:0] cfg, input logic glitch, output logic [15:0] res,
                      output logic [1:0] oe_seen, output int conv_len);
    int i;
    res = 16'h0000;
    o_frame <= 1'b0;
    cyc(8);
    oe_seen[1] = i_serial_result_oe;
    for (i = 0; i < 16; i++) begin
      // Data changes with the falling edge; past the word, the line keeps toggling
      o_sdi <= (i < 7) ? cfg[6 - i] : ~o_sdi;
      cyc(5);
      o_shift_clk <= 1'b1;
      cyc(1);
      // A released line reads as the inverse of the gated-low result pin, so as one
      res = {res[14:0], i_serial_result_oe ? i_serial_result_out : ~i_serial_result_out};
      cyc(2);
      o_shift_clk <= 1'b0;
    end
    cyc(8);
    // Acquisition since the last end is well over 75 cycles here
    o_frame <= 1'b1;
    conv_len = 0;
    i = 0;
    while (i_converting !== 1'b1 && i < 10) begin
      cyc(1);
      i++;
    end
    // Count the conversion, optionally pulsing frame low and high inside it
    while (i_converting === 1'b1 && conv_len < 200) begin
      if (glitch && conv_len == 10) o_frame <= 1'b0;
      if (glitch && conv_len == 14) o_frame <= 1'b1;
      if (conv_len == 5) oe_seen[0] = i_serial_result_oe;
      cyc(1);
      conv_len++;
    end
  endtask
endmodule // madc_host_model

//--- madc_pkg.sv
// Constants shared by the converter control block and its self-checking bench.
// Assumes a single 50 MHz core clock; all times become cycle counts here.
package madc_pkg;
  localparam int unsigned MADC_CLK_MHZ = 50; // Core clock rate in MHz
  localparam int unsigned MADC_CONV_NS = 3500; // Longest conversion time, ns
  localparam int unsigned MADC_CONV_CYC = (MADC_CONV_NS * MADC_CLK_MHZ) / 1000; // Cycles, rounded down
  localparam int unsigned MADC_ACQ_NS = 1500; // Least acquisition time owed by the host, ns
  localparam int unsigned MADC_ACQ_CYC = (MADC_ACQ_NS * MADC_CLK_MHZ + 999) / 1000; // Cycles, rounded up
  localparam int unsigned MADC_CFG_BITS = 7; // Configuration word length
  // Field positions of the configuration word, first shifted bit is bit 6
  localparam int unsigned MADC_F_SINGLE = 6; // Single-ended select
  localparam int unsigned MADC_F_ODD = 5; // Odd / sign select
  localparam int unsigned MADC_F_ADDR_HI = 4; // Pair address bit 1
  localparam int unsigned MADC_F_ADDR_LO = 3; // Pair address bit 0
  localparam int unsigned MADC_F_SHARED = 2; // Shared-negative select
  localparam int unsigned MADC_F_UNIPOLAR = 1; // Polarity mode select
  localparam int unsigned MADC_F_SLEEP = 0; // Power-down request
  localparam logic [6:0] MADC_CFG_RESET = 7'h00; // Configuration after reset
  localparam logic [3:0] MADC_SEL_GND = 4'h8; // Negative-input code for ground
  localparam logic [3:0] MADC_SEL_NONE = 4'hf; // No input selected
  typedef enum logic [1:0] {MADC_ACQUIRE, MADC_CONVERT, MADC_SLEEP} madc_state_t; // Core phases
endpackage : madc_pkg

//--- madc_sar_step.sv
// Successive-approximation bit register: resolves one bit per step, MSB first.
// Assumes the comparator input is a plain same-clock level from the analog front.
`timescale 1ns/100ps
module madc_sar_step #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_start, // Begin a new approximation
  input wire logic i_step, // Decide the current bit
  input wire logic i_cmp_high, // Comparator: input above trial level
  output logic [WIDTH-1:0] o_word, // Current approximation
  output logic o_done // Pulse when the last bit is decided
);
  logic [WIDTH-1:0] trial_reg; // One-hot trial bit
  // Refuse widths the one-hot trial register cannot serve
  if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
    $error("madc_sar_step: WIDTH out of range");
  end
  // Trial bit walks from MSB to LSB, keeping or dropping each bit
  always_ff @(posedge i_core_clk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      trial_reg <= '0;
      o_word <= '0;
    end else if (i_start) begin
      trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      o_word <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (i_step && trial_reg != '0) begin
      if (!i_cmp_high) o_word <= (o_word & ~trial_reg) | (trial_reg >> 1); // see (RL5)
      else o_word <= o_word | (trial_reg >> 1);
      trial_reg <= trial_reg >> 1;
      if (trial_reg[0]) o_done <= 1'b1;
    end
  end
endmodule // madc_sar_step

//--- testbench.sv
// Self-checking bench for the converter control block, driven through the host model.
// Assumes a 50 MHz core clock and a short conversion of 32 cycles.
`timescale 1ns/100ps
module testbench import madc_pkg::*;;
  logic clk, rst_n, cmp, frame, sck, serial_config_in, serial_result_out, oe, polarity_mode_select, power_down_request, conv;
  logic [3:0] pos, neg; // Mux selects seen
  logic [15:0] res; // Result shifted out
  logic [1:0] oe2; // Output enable during transfer and conversion
  int len, k, cycles, checked, n_fail;
  logic prev_uni, prev_cmp; // Polarity and comparator level of the conversion being shifted out
  // Configurations with expected mux selects
  logic [6:0] cfg [6] = '{7'h02, 7'h3a, 7'h6a, 7'h56, 7'h00, 7'h03};
  logic [3:0] pos_exp [6] = '{4'h0, 4'h7, 4'h3, 4'h4, 4'h0, 4'h0};
  logic [3:0] neg_exp [6] = '{4'h1, 4'h6, MADC_SEL_GND, 4'h7, 4'h1, 4'h1};
  madc_ctrl #(.RES_BITS(16), .CONV_CYC(32)) madc_ctrl_i (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_frame_and_start_pin(frame), .i_shift_clk(sck), .i_serial_config_in(serial_config_in), .i_cmp_high(cmp),
    .o_serial_result_out(serial_result_out), .o_serial_result_oe(oe), .o_pos_select(pos), .o_neg_select(neg),
    .o_unipolar(polarity_mode_select), .o_sleeping(power_down_request), .o_converting(conv));
  madc_host_model madc_host_model_i (.i_core_clk(clk), .i_serial_result_out(serial_result_out),
    .i_serial_result_oe(oe), .i_converting(conv), .o_frame(frame), .o_shift_clk(sck), .o_sdi(serial_config_in));
  // Compare one value and count it
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Core clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    cmp = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    madc_host_model_i.cyc(4);
    madc_host_model_i.xfer(7'h00, 1'b0, res, oe2, len);
    prev_uni = 1'b0;
    prev_cmp = 1'b0;
    for (k = 0; k < 6; k++) begin
      cmp <= k[0];
      madc_host_model_i.xfer(cfg[k], k == 2, res, oe2, len);
      chk("conv_len_ok", 16'h0001, {15'h0000, len >= 32 && len <= 40});
      chk("oe_in_frame", 16'h0001, {15'h0000, oe2[1]});
      chk("oe_converting", 16'h0000, {15'h0000, oe2[0]});
      madc_host_model_i.cyc(2);
      chk("pos_select", {12'h000, pos_exp[k]}, {12'h000, pos});
      chk("neg_select", {12'h000, neg_exp[k]}, {12'h000, neg});
      chk("unipolar", {15'h0000, cfg[k][1]}, {15'h0000, polarity_mode_select});
      // All ones or all zeros from the comparator; bipolar flips the top bit
      chk("result", (prev_cmp ? 16'hffff : 16'h0000) ^ {~prev_uni, 15'h0000}, res);
      prev_uni = cfg[k][1];
      prev_cmp = k[0];
    end
    chk("sleeping", 16'h0001, {15'h0000, power_down_request});
    madc_host_model_i.xfer(7'h02, 1'b0, res, oe2, len);
    madc_host_model_i.cyc(2);
    chk("result_after_sleep", 16'hffff, res);
    chk("awake", 16'h0000, {15'h0000, power_down_request});
    summarize();
  end
endmodule // testbench
